/* File: scc_smbus_target.sv */
// Serial-bus target holding the output-enable and spread/amplitude bytes.
// Assumes the host drives the bus clock much slower than sys_clk_in.
//
// What this block does
// - Acknowledge own write address after a start.
// - Acknowledge the start index byte.
// - Acknowledge the byte count in a write.
// - Store counted bytes at consecutive indices, ack each.
// - Bus address chosen by latched address strap.
// - Read answer begins with the byte count.
// - Then registers from index upward, ascending.
// - Byte 0 bits 2,1 enable pairs, reset 1.
// - Byte 1 bits 7:6 report latched spread strap.
// - Byte 1 bit 5 hands spread to software.
// - Software spread code: off, quarter, reserved, half.
// - Software spread bits ignored unless override set.
// - Byte 1 bits 1:0 set swing, reset 10.
`timescale 1ns/1ps
module scc_smbus_target #(
   parameter logic [7:0] READ_BYTE_COUNT = scc_pkg::BYTE_COUNT
) (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Serial bus pins; data is open drain.
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Straps.
   input wire logic bus_address_strap_in,
   input wire logic [1:0] spread_strap_in,
   // Control levels for the clock outputs.
   output scc_pkg::scc_ctrl_t ctrl_out
);

   logic [4:0] sync_q;
   logic scl_s;
   logic sda_s;
   logic scl_d;
   logic sda_d;
   logic [1:0] settle;
   logic strap_done;
   logic addr_sel;
   logic [1:0] spread_rb;
   scc_pkg::scc_state_t state;
   scc_pkg::scc_kind_t kind;
   logic [3:0] bitcnt;
   logic [7:0] rx_shift;
   logic [7:0] tx_shift;
   logic is_read;
   logic [7:0] ptr;
   logic [7:0] wleft;
   logic [7:0] oe_reg;
   logic [5:0] ss_reg;
   logic sda_oe;

   // Pins and straps cross into the device clock here.
   scc_sync #(
      .W(5),
      .RST_VAL(5'h1F)
   ) u_sync (
      .clk_in(sys_clk_in),
      .rst_in(rst_in),
      .d_in({scl_in, sda_in, bus_address_strap_in, spread_strap_in}),
      .q_out(sync_q)
   );

   assign scl_s = sync_q[4];
   assign sda_s = sync_q[3];

   // Edge and condition detection on the synchronised bus lines.
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_evt = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_evt = scl_s & scl_d & ~sda_d & sda_s;
   wire byte_in = (bitcnt == 4'h8);

   // Address decode from the latched strap.
   wire [6:0] dev_addr = addr_sel ? scc_pkg::ADDR_STRAP_HIGH
                                  : scc_pkg::ADDR_STRAP_LOW;
   wire addr_match = (rx_shift[7:1] == dev_addr);

   // Register read mux; unmapped indices read a fixed value.
   wire sel_oe = (ptr == scc_pkg::IDX_OUTPUT_ENABLE_CTRL);
   wire sel_ss = (ptr == scc_pkg::IDX_SPREAD_AMPLITUDE_CTRL);
   wire [7:0] ss_full = {spread_rb, ss_reg};
   wire [7:0] rd_data = sel_oe ? oe_reg
                      : sel_ss ? ss_full
                      : scc_pkg::UNMAPPED_READ;

   // A data byte lands as its acknowledge begins, while count remains.
   wire wr_strobe = (state == scc_pkg::ST_RX) & scl_fall & byte_in &
                    (kind == scc_pkg::K_DATA) & (wleft != 8'h00) &
                    ~start_evt & ~stop_evt;
   wire [7:0] next_oe = (oe_reg & ~scc_pkg::OE_WMASK) |
                        (rx_shift & scc_pkg::OE_WMASK);
   wire [7:0] next_ss_full = (ss_full & ~scc_pkg::SS_WMASK) |
                             (rx_shift & scc_pkg::SS_WMASK);

   // Effective spread: strap unless software override is set.
   wire ovr = ss_reg[scc_pkg::SS_OVR_BIT];
   wire [1:0] sw_spread = ss_reg[scc_pkg::SS_SW_MSB:scc_pkg::SS_SW_LSB];
   wire [1:0] strap_spread = (spread_rb == scc_pkg::STRAP_HIGH)
                             ? scc_pkg::SPREAD_HALF
                             : (spread_rb == scc_pkg::STRAP_MID)
                             ? scc_pkg::SPREAD_QUARTER
                             : scc_pkg::SPREAD_OFF;
   wire [1:0] next_spread = ovr ? sw_spread : strap_spread;

   // Open drain: the data line is only ever pulled low.
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_oe;

   // Line history for edge detection.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Straps are caught once, after the synchroniser has filled.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         settle <= 2'h0;
         strap_done <= 1'b0;
         addr_sel <= 1'b0;
         spread_rb <= scc_pkg::STRAP_LOW;
      end else if (!strap_done) begin
         settle <= settle + 2'h1;
         if (settle == scc_pkg::STRAP_SETTLE) begin
            strap_done <= 1'b1;
            addr_sel <= sync_q[2];
            spread_rb <= {sync_q[1], sync_q[0]};
         end
      end
   end

   // Configuration bytes; only writable fields take host data.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         oe_reg <= scc_pkg::OE_RESET;
         ss_reg <= scc_pkg::SS_RESET;
      end else if (wr_strobe && sel_oe) begin
         oe_reg <= next_oe;
      end else if (wr_strobe && sel_ss) begin
         ss_reg <= next_ss_full[5:0];
      end
   end

   // Outputs registered so the synthesiser sees clean levels.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ctrl_out <= '0;
      end else begin
         ctrl_out.pair1_output_enable <= oe_reg[scc_pkg::PAIR1_OE_BIT];
         ctrl_out.pair0_output_enable <= oe_reg[scc_pkg::PAIR0_OE_BIT];
         ctrl_out.spread_select <= next_spread;
         ctrl_out.amplitude <= ss_reg[scc_pkg::AMP_MSB:scc_pkg::AMP_LSB];
      end
   end

   // Serial engine. Received bits are taken on the clock's rising edge,
   // and the data line only changes after a falling edge, so the host
   // never sees it move while the clock is high. Stop, and start once the straps
   // are caught, win over everything, which also recovers from an aborted transfer.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state <= scc_pkg::ST_IDLE;
         kind <= scc_pkg::K_ADDR;
         bitcnt <= 4'h0;
         rx_shift <= 8'h00;
         tx_shift <= 8'h00;
         is_read <= 1'b0;
         ptr <= 8'h00;
         wleft <= 8'h00;
         sda_oe <= 1'b0;
      end else if (stop_evt) begin
         state <= scc_pkg::ST_IDLE;
         sda_oe <= 1'b0;
      end else if (start_evt && strap_done) begin
         state <= scc_pkg::ST_RX;
         kind <= scc_pkg::K_ADDR;
         bitcnt <= 4'h0;
         sda_oe <= 1'b0;
      end else begin
         case (state)
            scc_pkg::ST_RX: begin
               if (scl_rise && !byte_in) begin
                  rx_shift <= {rx_shift[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall && byte_in) begin
                  bitcnt <= 4'h0;
                  state <= scc_pkg::ST_ACK;
                  sda_oe <= 1'b1;
                  case (kind)
                     scc_pkg::K_ADDR: begin
                        if (addr_match) begin
                           is_read <= rx_shift[0];
                        end else begin
                           state <= scc_pkg::ST_IDLE;
                           sda_oe <= 1'b0;
                        end
                     end
                     scc_pkg::K_INDEX: ptr <= rx_shift;
                     scc_pkg::K_COUNT: wleft <= rx_shift;
                     default: begin
                        if (wleft != 8'h00) begin
                           ptr <= ptr + 8'h01;
                           wleft <= wleft - 8'h01;
                        end
                     end
                  endcase
               end
            end
            scc_pkg::ST_ACK: begin
               if (scl_fall) begin
                  if (kind == scc_pkg::K_ADDR && is_read) begin
                     // First count bit goes out on this same edge.
                     state <= scc_pkg::ST_TX;
                     sda_oe <= ~READ_BYTE_COUNT[7];
                     tx_shift <= {READ_BYTE_COUNT[6:0], 1'b0};
                     bitcnt <= 4'h1;
                  end else begin
                     state <= scc_pkg::ST_RX;
                     sda_oe <= 1'b0;
                     bitcnt <= 4'h0;
                     case (kind)
                        scc_pkg::K_ADDR: kind <= scc_pkg::K_INDEX;
                        scc_pkg::K_INDEX: kind <= scc_pkg::K_COUNT;
                        default: kind <= scc_pkg::K_DATA;
                     endcase
                  end
               end
            end
            scc_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (byte_in) begin
                     state <= scc_pkg::ST_RACK;
                     sda_oe <= 1'b0;
                  end else begin
                     sda_oe <= ~tx_shift[7];
                     tx_shift <= {tx_shift[6:0], 1'b0};
                     bitcnt <= bitcnt + 4'h1;
                  end
               end
            end
            scc_pkg::ST_RACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     state <= scc_pkg::ST_IDLE;
                  end else begin
                     state <= scc_pkg::ST_TX;
                     tx_shift <= rd_data;
                     ptr <= ptr + 8'h01;
                     bitcnt <= 4'h0;
                  end
               end
            end
            default: begin
               state <= scc_pkg::ST_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

endmodule

/* File: scc_pkg.sv */
// Shared constants and types for the clock-configuration bus target.
// Assumes a single device clock domain; the serial pins are sampled in it.
package scc_pkg;

   // Seven-bit bus addresses picked by the latched address strap.
   localparam logic [6:0] ADDR_STRAP_LOW = 7'h68;
   localparam logic [6:0] ADDR_STRAP_HIGH = 7'h6A;

   // Register indices.
   localparam logic [7:0] IDX_OUTPUT_ENABLE_CTRL = 8'h00;
   localparam logic [7:0] IDX_SPREAD_AMPLITUDE_CTRL = 8'h01;

   // Output enable register layout, reset value and writable bits.
   localparam int PAIR1_OE_BIT = 2;
   localparam int PAIR0_OE_BIT = 1;
   localparam logic [7:0] OE_RESET = 8'hFF;
   localparam logic [7:0] OE_WMASK = 8'h06;

   // Spread and amplitude register layout; the low six bits are stored.
   localparam int SS_RB_MSB = 7;
   localparam int SS_RB_LSB = 6;
   localparam int SS_OVR_BIT = 5;
   localparam int SS_SW_MSB = 4;
   localparam int SS_SW_LSB = 3;
   localparam int AMP_MSB = 1;
   localparam int AMP_LSB = 0;
   // Override bit clear at reset, so the strap governs spread until set.
   localparam logic [5:0] SS_RESET = 6'h06;
   localparam logic [7:0] SS_WMASK = 8'h3B;

   // Three-level spread strap readback codes.
   localparam logic [1:0] STRAP_LOW = 2'h0;
   localparam logic [1:0] STRAP_MID = 2'h1;
   localparam logic [1:0] STRAP_HIGH = 2'h3;

   // Spread amount codes driven to the synthesiser.
   localparam logic [1:0] SPREAD_OFF = 2'h0;
   localparam logic [1:0] SPREAD_QUARTER = 2'h1;
   localparam logic [1:0] SPREAD_HALF = 2'h3;

   // Read answer details.
   localparam logic [7:0] BYTE_COUNT = 8'h08;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Cycles after reset release before the straps are captured.
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // Bit-level states of the serial engine.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_TX,
      ST_RACK
   } scc_state_t;

   // Meaning of the byte being received.
   typedef enum logic [1:0] {
      K_ADDR,
      K_INDEX,
      K_COUNT,
      K_DATA
   } scc_kind_t;

   // Control levels handed to the clock outputs.
   typedef struct packed {
      logic pair1_output_enable;
      logic pair0_output_enable;
      logic [1:0] spread_select;
      logic [1:0] amplitude;
   } scc_ctrl_t;

endpackage

/* File: scc_sync.sv */
// Two-flop synchroniser for a group of asynchronous inputs.
// Assumes each bit is independent; no bus coherence is implied.
`timescale 1ns/1ps
module scc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Asynchronous input and its synchronised copy.
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);

   logic [W-1:0] meta;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end

endmodule

/* File: scc_host.sv */
// Behavioural bus host that drives the link clock and pulls data low.
// Assumes a pulled-up data wire built by the bench from all enables.
`timescale 1ns/1ps
module scc_host (
   // Wire level and host drives.
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   // The link clock stands high between frames.
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // One bit in 800 ns; sampled late in the high phase, so slow answers
   // from the target still land in time.
   task automatic bit_io(input logic b, output logic r);
      scl_out = 1'b0;
      #100 sda_low_out = !b;
      #300 scl_out = 1'b1;
      #399 r = sda_in;
      #1;
   endtask
   // Start or repeated start.
   task automatic start();
      scl_out = 1'b0;
      #100 sda_low_out = 1'b0;
      #300 scl_out = 1'b1;
      #400 sda_low_out = 1'b1;
      #400;
   endtask
   // Stop; the line is then released.
   task automatic stop();
      scl_out = 1'b0;
      #100 sda_low_out = 1'b1;
      #300 scl_out = 1'b1;
      #400 sda_low_out = 1'b0;
      #400;
   endtask
   // Send a byte, most significant bit first, and return the answer.
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // Take a byte and answer it; the last one gets a not-acknowledge.
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule

/* File: scc_smbus_target_sva.sv */
// Checker on the bus target's pins and control outputs.
// Assumes one clock domain and bus phases of at least four clocks.
`timescale 1ns/1ps
module scc_smbus_target_sva #(
   parameter logic [7:0] READ_BYTE_COUNT = scc_pkg::BYTE_COUNT
) (
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   // Straps and controls.
   input wire logic bus_address_strap_in,
   input wire logic [1:0] spread_strap_in,
   input wire scc_pkg::scc_ctrl_t ctrl_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   // Saturating age since reset; early strap capture may move controls.
   logic [3:0] since_rst;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         since_rst <= 4'h0;
      end else if (since_rst != 4'hF) begin
         since_rst <= since_rst + 4'h1;
      end
   end
   sequence s_reset_values;
      ctrl_out.pair1_output_enable && ctrl_out.pair0_output_enable
         && ctrl_out.amplitude == 2'h2;
   endsequence
   sequence s_hold;
      sda_oe_out [*4];
   endsequence
   property p_reset_quiet;
      $past(rst_in) |-> !sda_oe_out && ctrl_out == 6'h00;
   endproperty
   property p_reset_values;
      $fell(rst_in) |=> s_reset_values;
   endproperty
   property p_open_drain;
      sda_oe_out |-> sda_out == 1'b0;
   endproperty
   property p_oe_moves_low;
      $changed(sda_oe_out) |-> !scl_in;
   endproperty
   property p_ack_after_fall;
      $rose(sda_oe_out) |-> !$past(scl_in) && !$past(scl_in, 2);
   endproperty
   property p_bit_holds;
      $rose(sda_oe_out) |-> s_hold;
   endproperty
   property p_ctrl_on_ack;
      since_rst == 4'hF && $changed(ctrl_out)
         |-> sda_oe_out || $past(sda_oe_out);
   endproperty
   property p_quiet_start;
      since_rst < 4'h8 |-> !sda_oe_out;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not cleared in reset");
   a_reset_values: assert property (p_reset_values)
      else $error("control reset values wrong");
   a_open_drain: assert property (p_open_drain)
      else $error("data driven high");
   a_oe_moves_low: assert property (p_oe_moves_low)
      else $error("data moved while clock high");
   a_ack_after_fall: assert property (p_ack_after_fall)
      else $error("drive began too soon");
   a_bit_holds: assert property (p_bit_holds)
      else $error("driven bit too short");
   a_ctrl_on_ack: assert property (p_ctrl_on_ack)
      else $error("controls moved outside a write");
   a_quiet_start: assert property (p_quiet_start)
      else $error("answered before strap capture");
endmodule
bind scc_smbus_target scc_smbus_target_sva #(
   .READ_BYTE_COUNT(READ_BYTE_COUNT)
) u_scc_smbus_target_sva (
   .sys_clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
   .bus_address_strap_in, .spread_strap_in, .ctrl_out
);

/* File: scc_smbus_target_tb.sv */
// Self-checking bench: random indexed writes and block reads.
// Assumes the host model owns the bus; the data wire has a pull-up.
`timescale 1ns/1ps
module scc_smbus_target_tb;
   localparam logic [7:0] COUNT = 8'h08;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic adr_strap = 1'b0;
   logic [1:0] ss_strap = 2'h0;
   logic sda_out, sda_oe_out, scl, host_low, ack;
   logic [7:0] exp0, exp1, d0, d1, got;
   scc_pkg::scc_ctrl_t ctrl_out;
   wire logic sda = !(host_low | (sda_oe_out & !sda_out));
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;
   scc_smbus_target #(.READ_BYTE_COUNT(COUNT)) u_scc_smbus_target (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .bus_address_strap_in(adr_strap), .spread_strap_in(ss_strap),
      .ctrl_out(ctrl_out));
   scc_host u_scc_host (.sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
   // Clock, and a guard well beyond the expected twenty thousand cycles.
   always #50 sys_clk_in = !sys_clk_in;
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: byte %h not %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: ack %b not %b", $time, g, e);
      end
   endtask
   function automatic logic [7:0] addr_byte(input logic s, input logic r);
      return {s ? scc_pkg::ADDR_STRAP_HIGH : scc_pkg::ADDR_STRAP_LOW, r};
   endfunction
   function automatic logic [7:0] reg_exp(input logic [7:0] i);
      return (i == 8'h00) ? exp0 : (i == 8'h01) ? exp1 : 8'h00;
   endfunction
   // Spread follows the strap unless software has taken it over.
   task automatic chk_ctrl();
      logic [1:0] sp;
      sp = exp1[5] ? exp1[4:3] : ss_strap;
      chk_byte({2'h0, ctrl_out},
         {2'h0, exp0[2:1], sp, exp1[1:0]});
   endtask
   // Indexed write at index 0 with count c; two data bytes always sent.
   task automatic wr(input logic [7:0] a, input logic [7:0] c,
         input logic ok);
      logic [7:0] b [5];
      b = '{a, 8'h00, c, d0, d1};
      @(posedge sys_clk_in) #1;
      u_scc_host.start();
      foreach (b[i]) begin
         u_scc_host.put(b[i], ack);
         chk_bit(ack, ok);
      end
      u_scc_host.stop();
   endtask
   // Block read of the count and four bytes, crossing unmapped indices.
   task automatic rd(input logic [7:0] idx);
      @(posedge sys_clk_in) #1;
      u_scc_host.start();
      u_scc_host.put(addr_byte(adr_strap, 1'b0), ack);
      chk_bit(ack, 1'b1);
      u_scc_host.put(idx, ack);
      chk_bit(ack, 1'b1);
      u_scc_host.start();
      u_scc_host.put(addr_byte(adr_strap, 1'b1), ack);
      chk_bit(ack, 1'b1);
      u_scc_host.get(1'b0, got);
      chk_byte(got, COUNT);
      for (int i = 0; i < 4; i++) begin
         u_scc_host.get(i == 3, got);
         chk_byte(got, reg_exp(idx + i[7:0]));
      end
      u_scc_host.stop();
   endtask
   // Each pass resets with new straps, then writes and reads back.
   initial begin
      logic [7:0] c;
      void'($urandom(29673));
      // Data bytes are sent by the misaddressed write before the loop draws them; never float them.
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      for (int p = 0; p < 4; p++) begin
         @(posedge sys_clk_in) #1 rst_in = 1'b1;
         adr_strap = p[0];
         ss_strap = (p == 2) ? 2'h3 : p[1:0] & 2'h1;
         repeat (12) @(posedge sys_clk_in);
         #1 rst_in = 1'b0;
         repeat (12) @(posedge sys_clk_in);
         exp0 = 8'hFF;
         exp1 = {ss_strap, 6'h06};
         chk_ctrl();
         rd(8'($urandom_range(1)));
         wr(addr_byte(!adr_strap, 1'b0), 8'h02, 1'b0);
         for (int k = 0; k < 4; k++) begin
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            d1[4:3] = k[1:0];
            d1[5] = (p < 2) | d1[5];
            c = (p < 2) ? 8'h02 : 8'($urandom_range(2, 1));
            wr(addr_byte(adr_strap, 1'b0), c, 1'b1);
            exp0 = (exp0 & 8'hF9) | (d0 & 8'h06);
            if (c == 8'h02) exp1 = (exp1 & 8'hC4) | (d1 & 8'h3B);
            chk_ctrl();
            rd(8'($urandom_range(1)));
         end
      end
      finish_test();
   end
endmodule
